// *** dv/charger_control_regs_low_sva.sv ***
// Checker for the low charger register bank, watching top-level ports only.
// Assumes one clock and that the bench pulses watchdog and reset while idle.
`default_nettype none
module charger_control_regs_low_sva (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       register_reset_in,
  input wire logic       watchdog_expired_in,
  input wire logic       high_impedance_mode_out,
  input wire logic [4:0] input_current_limit_out,
  input wire logic       watchdog_kick_out,
  input wire logic       boost_enable_out,
  input wire logic       charge_active_out,
  input wire logic [2:0] system_min_voltage_out,
  input wire logic       boost_current_limit_out,
  input wire logic       input_fet_low_resistance_out,
  input wire logic [5:0] fast_charge_current_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_kick_pulse; watchdog_kick_out |=> !watchdog_kick_out; endproperty
  a_kick_pulse: assert property (p_kick_pulse)
    else $error("kick pulse longer than one cycle");
  property p_boost_wins; charge_active_out |-> !boost_enable_out; endproperty
  a_boost_wins: assert property (p_boost_wins)
    else $error("charging while boost enabled");
  property p_zero_off;
    charge_active_out |-> fast_charge_current_out != charger_regs_pkg::FAST_CHARGE_CURRENT_OFF;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("charging with zero charge current");
  property p_clamp; fast_charge_current_out <= charger_regs_pkg::FAST_CHARGE_CURRENT_MAX; endproperty
  a_clamp: assert property (p_clamp)
    else $error("charge current code above clamp");
  property p_fet;
    (boost_enable_out || input_current_limit_out >= charger_regs_pkg::ILIM_FET_THRESH)
      |-> input_fet_low_resistance_out;
  endproperty
  a_fet: assert property (p_fet)
    else $error("input fet not full on");
  property p_wd_restore;
    watchdog_expired_in && !register_reset_in |-> ##2 (!high_impedance_mode_out &&
      !boost_enable_out && boost_current_limit_out && fast_charge_current_out == 6'h22);
  endproperty
  a_wd_restore: assert property (p_wd_restore)
    else $error("watchdog did not restore fields");
  property p_wd_keep;
    watchdog_expired_in |-> ##2 $stable(system_min_voltage_out) [*3];
  endproperty
  a_wd_keep: assert property (p_wd_keep)
    else $error("system minimum changed on watchdog");
  property p_reg_reset;
    register_reset_in |-> ##2 (input_current_limit_out == 5'h17 &&
      system_min_voltage_out == 3'h5 && fast_charge_current_out == 6'h22);
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset values wrong");
endmodule
`default_nettype wire

// *** dv/charger_control_regs_low_tb_top.sv ***
// Top bench for the low charger register bank with an I2C host model.
// Assumes the design ACKs its slave address and idles SDA released.
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module charger_control_regs_low_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in, rst_b_in, scl, sda_low, sda, sda_o, sda_oe_b;
  logic       det, psel, ce_b, rrst, wdx;
  logic       high_impedance_mode, flt, light, kick, boost, chg, bmin, blim, fet;
  logic [4:0] ilim;
  logic [2:0] smin;
  logic [5:0] fast_charge_current;
  int         errors, checks, cycles, kicks;
  assign sda = !((!sda_oe_b && !sda_o) || sda_low);
  charger_control_regs_low charger_control_regs_low_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_b_out(sda_oe_b), .source_detect_done_in(det),
    .power_source_select_in(psel), .charge_enable_b_in(ce_b),
    .register_reset_in(rrst), .watchdog_expired_in(wdx),
    .high_impedance_mode_out(high_impedance_mode), .status_pin_float_out(flt),
    .input_current_limit_out(ilim), .light_load_mode_disable_out(light),
    .watchdog_kick_out(kick), .boost_enable_out(boost), .charge_active_out(chg),
    .system_min_voltage_out(smin), .boost_min_battery_select_out(bmin),
    .boost_current_limit_out(blim), .input_fet_low_resistance_out(fet),
    .fast_charge_current_out(fast_charge_current));
  i2c_host_model i2c_host_model_i (
    .clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = !clk_in;
  end
  // ---------------------------------------------------------------
  // Monitors and run control
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (kick === 1'b1) kicks++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(negedge clk_in);
  endtask
  task automatic rd3(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    i2c_host_model_i.rd(8'h00, 3);
    `CHK("input_source_control", e0, i2c_host_model_i.rd_q[0])
    `CHK("charge_boost_config", e1, i2c_host_model_i.rd_q[1])
    `CHK("charge_current_control", e2, i2c_host_model_i.rd_q[2])
  endtask
  initial begin
    {rst_b_in, det, psel, ce_b, rrst, wdx} = 6'h00;
    {errors, checks, cycles, kicks} = '0;
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (20) @(negedge clk_in);
    rd3(8'h17, 8'h1A, 8'hA2);
    i2c_host_model_i.wr(7'h35, 8'h00, 1, 8'h00, 8'h00, 8'h00);
    `CHK("foreign ack", 1'b0, i2c_host_model_i.ack_q)
    // Full-on FET bit set with a limit below threshold: only the bit can turn it on
    i2c_host_model_i.wr(charger_regs_pkg::SLAVE_ADDR, 8'h00, 3, 8'hE5, 8'h5B, 8'h7F);
    `CHK("own ack", 1'b1, i2c_host_model_i.ack_q)
    settle();
    `CHK("hiz", 1'b1, high_impedance_mode)
    `CHK("float", 1'b1, flt)
    `CHK("fet", 1'b1, fet)
    `CHK("kicks", 1, kicks)
    `CHK("bmin", 1'b1, bmin)
    `CHK("charge", 1'b1, chg)
    rd3(8'hE5, 8'h1B, 8'h72);
    ce_b = 1'b1;
    settle();
    `CHK("charge pin", 1'b0, chg)
    ce_b = 1'b0;
    // Nonzero charge code, so only boost can hold charging off
    i2c_host_model_i.wr(charger_regs_pkg::SLAVE_ADDR, 8'h01, 2, 8'hB5, 8'h22, 8'h00);
    settle();
    `CHK("boost charge", 1'b0, chg)
    `CHK("boost fet", 1'b1, fet)
    `CHK("blim", 1'b0, blim)
    wdx = 1'b1;
    @(negedge clk_in);
    wdx = 1'b0;
    rd3(8'h65, 8'h95, 8'hA2);
    `CHK("wd light", 1'b1, light)
    `CHK("wd smin", 3'h2, smin)
    `CHK("wd charge", 1'b1, chg)
    `CHK("wd fet", 1'b0, fet)
    psel = 1'b1;
    det = 1'b1;
    settle();
    `CHK("psel high", 5'h04, ilim)
    det = 1'b0;
    i2c_host_model_i.wr(charger_regs_pkg::SLAVE_ADDR, 8'h00, 1, 8'h29, 8'h00, 8'h00);
    settle();
    `CHK("host limit", 5'h09, ilim)
    `CHK("reserved code", 1'b0, flt)
    `CHK("fet limit", 1'b1, fet)
    psel = 1'b0;
    det = 1'b1;
    settle();
    `CHK("psel low", 5'h17, ilim)
    i2c_host_model_i.wr(charger_regs_pkg::SLAVE_ADDR, 8'h02, 1, 8'h80, 8'h00, 8'h00);
    settle();
    `CHK("zero fast_charge_current", 6'h00, fast_charge_current)
    `CHK("zero charge", 1'b0, chg)
    i2c_host_model_i.rd(8'h0C, 1);
    `CHK("beyond", 8'hFF, i2c_host_model_i.rd_q[0])
    rrst = 1'b1;
    @(negedge clk_in);
    rrst = 1'b0;
    rd3(8'h17, 8'h1A, 8'hA2);
    complete_run();
  end
endmodule
bind charger_control_regs_low charger_control_regs_low_sva charger_control_regs_low_sva_i (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .register_reset_in(register_reset_in),
  .watchdog_expired_in(watchdog_expired_in),
  .high_impedance_mode_out(high_impedance_mode_out),
  .input_current_limit_out(input_current_limit_out),
  .watchdog_kick_out(watchdog_kick_out), .boost_enable_out(boost_enable_out),
  .charge_active_out(charge_active_out), .system_min_voltage_out(system_min_voltage_out),
  .boost_current_limit_out(boost_current_limit_out),
  .input_fet_low_resistance_out(input_fet_low_resistance_out),
  .fast_charge_current_out(fast_charge_current_out));
`default_nettype wire

// *** dv/i2c_host_model.sv ***
// Host side I2C master model driving an open-drain bus, no stretching.
// Assumes the bench resolves the SDA wire with a pull-up.
`default_nettype none
module i2c_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_q [0:2];
  logic       ack_q;
  logic       s_q;
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  // Ten cycles per phase keeps each SCL level well above the sync depth
  task automatic hold();
    repeat (10) @(negedge clk_in);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    hold();
    scl_out = 1'b1;
    hold();
    sda_low_out = 1'b1;
    hold();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    hold();
    sda_low_out = 1'b1;
    hold();
    scl_out = 1'b1;
    hold();
    sda_low_out = 1'b0;
    hold();
  endtask
  task automatic bit_io(input logic b, output logic s);
    hold();
    sda_low_out = !b;
    hold();
    scl_out = 1'b1;
    hold();
    s = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, s_q);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
                    input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] q;
    start();
    xfer({a, 1'b0}, 1'b1, q);
    ack_q = !s_q;
    xfer(p, 1'b1, q);
    if (n > 0) xfer(b0, 1'b1, q);
    if (n > 1) xfer(b1, 1'b1, q);
    if (n > 2) xfer(b2, 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] q;
    start();
    xfer({charger_regs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q);
    xfer(p, 1'b1, q);
    start();
    xfer({charger_regs_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q);
    for (int k = 0; k < n; k++) xfer(8'hFF, k == n - 1, rd_q[k]);
    stop();
  endtask
endmodule
`default_nettype wire

// *** rtl/charger_control_regs_low.sv ***
// Low configuration bank (0x00..0x02) of the charger, behind an I2C slave.
// Assumes a single clock; pins arrive asynchronously, reset and watchdog
// events come from logic on the same clock.
`default_nettype none
module charger_control_regs_low (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b_out,
  input  wire logic       source_detect_done_in,
  input  wire logic       power_source_select_in,
  input  wire logic       charge_enable_b_in,
  input  wire logic       register_reset_in,
  input  wire logic       watchdog_expired_in,
  output logic            high_impedance_mode_out,
  output logic            status_pin_float_out,
  output logic [4:0]      input_current_limit_out,
  output logic            light_load_mode_disable_out,
  output logic            watchdog_kick_out,
  output logic            boost_enable_out,
  output logic            charge_active_out,
  output logic [2:0]      system_min_voltage_out,
  output logic            boost_min_battery_select_out,
  output logic            boost_current_limit_out,
  output logic            input_fet_low_resistance_out,
  output logic [5:0]      fast_charge_current_out
);

  typedef enum logic [2:0] {IDLE, ADDR, PTR, WDATA, RDATA} i2c_state_t;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] wd_restore(input logic [7:0] cur,
                                            input logic [7:0] por,
                                            input logic [7:0] mask);
    wd_restore = (cur & ~mask) | (por & mask);
  endfunction

  function automatic logic [5:0] clamp_fast_charge_current(input logic [5:0] code);
    clamp_fast_charge_current = (code > charger_regs_pkg::FAST_CHARGE_CURRENT_MAX) ? charger_regs_pkg::FAST_CHARGE_CURRENT_MAX : code;
  endfunction

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_b;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  // Stage 0 feeds stage 1 only; stage 2 exists for edge detection
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [2:0] det_q;
  logic [1:0] psel_q;
  logic [1:0] ce_q;
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      scl_q  <= 3'h7;
      sda_q  <= 3'h7;
      det_q  <= 3'h0;
      psel_q <= 2'h0;
      ce_q   <= 2'h3;
    end else begin
      scl_q  <= {scl_q[1:0], scl_in};
      sda_q  <= {sda_q[1:0], sda_in};
      det_q  <= {det_q[1:0], source_detect_done_in};
      psel_q <= {psel_q[0], power_source_select_in};
      ce_q   <= {ce_q[0], charge_enable_b_in};
    end
  end

  wire scl_rise   = scl_q[1] & ~scl_q[2];
  wire scl_fall   = ~scl_q[1] & scl_q[2];
  wire sda_now    = sda_q[1];
  wire start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire stop_cond  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  wire det_rise   = det_q[1] & ~det_q[2];

  // ---------------------------------------------------------------
  // I2C slave engine
  // ---------------------------------------------------------------
  i2c_state_t st_q;
  logic       ack_phase_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       master_nack_q;
  logic       sda_drive_q;
  logic       wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] input_source_control_q;
  logic [7:0] charge_boost_config_q;
  logic [7:0] charge_current_control_q;
  logic [7:0] rd_data;

  wire addr_match = (shift_q[7:1] == charger_regs_pkg::SLAVE_ADDR);
  wire byte_done  = (bit_cnt_q == 4'h8);

  // Unbuilt registers up to 0x0B read as zero; beyond the map reads 0xFF
  assign rd_data = (ptr_q == charger_regs_pkg::OFS_INPUT_SOURCE) ? input_source_control_q :
                   (ptr_q == charger_regs_pkg::OFS_CHARGE_BOOST) ? charge_boost_config_q :
                   (ptr_q == charger_regs_pkg::OFS_CHARGE_CURR)  ? charge_current_control_q :
                   (ptr_q <= charger_regs_pkg::OFS_LAST) ? charger_regs_pkg::READ_UNBUILT :
                   charger_regs_pkg::READ_BEYOND_MAP;

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      st_q          <= IDLE;
      ack_phase_q   <= 1'b0;
      bit_cnt_q     <= 4'h0;
      shift_q       <= 8'h00;
      tx_q          <= 8'h00;
      ptr_q         <= 8'h00;
      master_nack_q <= 1'b0;
      sda_drive_q   <= 1'b0;
      wr_stb_q      <= 1'b0;
      wr_addr_q     <= 8'h00;
      wr_data_q     <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_cond) begin
        st_q        <= ADDR;
        ack_phase_q <= 1'b0;
        bit_cnt_q   <= 4'h0;
        sda_drive_q <= 1'b0;
      end else if (stop_cond) begin
        st_q        <= IDLE;
        sda_drive_q <= 1'b0;
      end else if (st_q != IDLE && scl_rise) begin
        if (ack_phase_q) begin
          master_nack_q <= sda_now;
        end else begin
          shift_q   <= {shift_q[6:0], sda_now};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end else if (st_q != IDLE && scl_fall) begin
        if (!ack_phase_q && byte_done) begin
          ack_phase_q <= 1'b1;
          bit_cnt_q   <= 4'h0;
          unique case (st_q)
            ADDR: begin
              // Foreign address: stay off the bus until the next START
              sda_drive_q <= addr_match;
              if (!addr_match) begin
                st_q <= IDLE;
              end
            end
            PTR: begin
              ptr_q       <= shift_q;
              sda_drive_q <= 1'b1;
            end
            WDATA: begin
              wr_stb_q    <= 1'b1;
              wr_addr_q   <= ptr_q;
              wr_data_q   <= shift_q;
              ptr_q       <= ptr_q + 8'h01;
              sda_drive_q <= 1'b1;
            end
            RDATA: begin
              sda_drive_q <= 1'b0;
            end
            default: begin
              sda_drive_q <= 1'b0;
            end
          endcase
        end else if (ack_phase_q) begin
          ack_phase_q <= 1'b0;
          unique case (st_q)
            ADDR: begin
              if (shift_q[0]) begin
                st_q        <= RDATA;
                tx_q        <= rd_data;
                sda_drive_q <= ~rd_data[7];
                ptr_q       <= ptr_q + 8'h01;
              end else begin
                st_q        <= PTR;
                sda_drive_q <= 1'b0;
              end
            end
            PTR: begin
              st_q        <= WDATA;
              sda_drive_q <= 1'b0;
            end
            WDATA: begin
              sda_drive_q <= 1'b0;
            end
            RDATA: begin
              if (master_nack_q) begin
                st_q        <= IDLE;
                sda_drive_q <= 1'b0;
              end else begin
                tx_q        <= rd_data;
                sda_drive_q <= ~rd_data[7];
                ptr_q       <= ptr_q + 8'h01;
              end
            end
            default: begin
              sda_drive_q <= 1'b0;
            end
          endcase
        end else if (st_q == RDATA) begin
          tx_q        <= {tx_q[6:0], 1'b0};
          sda_drive_q <= ~tx_q[6];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  wire wr00 = wr_stb_q && (wr_addr_q == charger_regs_pkg::OFS_INPUT_SOURCE);
  wire wr01 = wr_stb_q && (wr_addr_q == charger_regs_pkg::OFS_CHARGE_BOOST);
  wire wr02 = wr_stb_q && (wr_addr_q == charger_regs_pkg::OFS_CHARGE_CURR);
  wire [4:0] ilim_auto = psel_q[1] ? charger_regs_pkg::ILIM_PSEL_HIGH
                                   : charger_regs_pkg::ILIM_PSEL_LOW;
  wire [7:0] wr02_val = {wr_data_q[7:6], clamp_fast_charge_current(wr_data_q[5:0])};

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      input_source_control_q <= charger_regs_pkg::POR_INPUT_SOURCE;
      charge_boost_config_q <= charger_regs_pkg::POR_CHARGE_BOOST;
      charge_current_control_q <= charger_regs_pkg::POR_CHARGE_CURR;
    end else if (register_reset_in) begin
      input_source_control_q <= charger_regs_pkg::POR_INPUT_SOURCE;
      charge_boost_config_q <= charger_regs_pkg::POR_CHARGE_BOOST;
      charge_current_control_q <= charger_regs_pkg::POR_CHARGE_CURR;
    end else if (watchdog_expired_in) begin
      // Only the watchdog-masked fields move; the rest hold
      input_source_control_q <= wd_restore(input_source_control_q, charger_regs_pkg::POR_INPUT_SOURCE,
                            charger_regs_pkg::WD_INPUT_SOURCE);
      charge_boost_config_q <= wd_restore(charge_boost_config_q, charger_regs_pkg::POR_CHARGE_BOOST,
                            charger_regs_pkg::WD_CHARGE_BOOST);
      charge_current_control_q <= wd_restore(charge_current_control_q, charger_regs_pkg::POR_CHARGE_CURR,
                            charger_regs_pkg::WD_CHARGE_CURR);
    end else begin
      // Host write beats detection in the same cycle
      if (wr00) begin
        input_source_control_q <= wr_data_q;
      end else if (det_rise) begin
        input_source_control_q <= {input_source_control_q[7:5], ilim_auto};
      end
      if (wr01) begin
        charge_boost_config_q <= wr_data_q;
      end else begin
        charge_boost_config_q[charger_regs_pkg::KICK_BIT] <= 1'b0;
      end
      if (wr02) begin
        charge_current_control_q <= wr02_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  wire [4:0] ilim      = input_source_control_q[charger_regs_pkg::ILIM_MSB:0];
  wire [5:0] fast_charge_current      = charge_current_control_q[charger_regs_pkg::FAST_CHARGE_CURRENT_MSB:0];
  wire       boost_on  = charge_boost_config_q[charger_regs_pkg::BOOST_BIT];
  wire       hiz_on    = input_source_control_q[charger_regs_pkg::HIZ_BIT];
  wire       stat_float = (input_source_control_q[charger_regs_pkg::STAT_MSB:charger_regs_pkg::STAT_LSB]
                           == charger_regs_pkg::STAT_FLOAT);
  wire       charge_on = charge_boost_config_q[charger_regs_pkg::CHG_BIT] & ~ce_q[1]
                         & ~boost_on
                         & (fast_charge_current != charger_regs_pkg::FAST_CHARGE_CURRENT_OFF);
  wire       fet_low   = boost_on
                         | charge_current_control_q[charger_regs_pkg::FET_BIT]
                         | (ilim >= charger_regs_pkg::ILIM_FET_THRESH);

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      sda_out                      <= 1'b0;
      sda_oe_b_out                 <= 1'b1;
      high_impedance_mode_out      <= 1'b0;
      status_pin_float_out         <= 1'b0;
      input_current_limit_out      <= 5'h00;
      light_load_mode_disable_out  <= 1'b0;
      watchdog_kick_out            <= 1'b0;
      boost_enable_out             <= 1'b0;
      charge_active_out            <= 1'b0;
      system_min_voltage_out       <= 3'h0;
      boost_min_battery_select_out <= 1'b0;
      boost_current_limit_out      <= 1'b0;
      input_fet_low_resistance_out <= 1'b0;
      fast_charge_current_out      <= 6'h00;
    end else begin
      // Open drain: data is always low, the enable does the work
      sda_out                      <= 1'b0;
      sda_oe_b_out                 <= ~sda_drive_q;
      high_impedance_mode_out      <= hiz_on;
      status_pin_float_out         <= stat_float;
      input_current_limit_out      <= ilim;
      light_load_mode_disable_out  <= charge_boost_config_q[charger_regs_pkg::LIGHT_BIT];
      watchdog_kick_out            <= charge_boost_config_q[charger_regs_pkg::KICK_BIT];
      boost_enable_out             <= boost_on;
      charge_active_out            <= charge_on;
      system_min_voltage_out       <=
        charge_boost_config_q[charger_regs_pkg::SYSMIN_MSB:charger_regs_pkg::SYSMIN_LSB];
      boost_min_battery_select_out <= charge_boost_config_q[charger_regs_pkg::BMIN_BIT];
      boost_current_limit_out      <= charge_current_control_q[charger_regs_pkg::BLIM_BIT];
      input_fet_low_resistance_out <= fet_low;
      fast_charge_current_out      <= fast_charge_current;
    end
  end

endmodule
`default_nettype wire

// *** rtl/charger_regs_pkg.sv ***
// Constants for the low configuration bank of the charger register file.
// Assumes a single 25 MHz clock domain and an I2C master outside the chip.
`default_nettype none
package charger_regs_pkg;
  // ---------------------------------------------------------------
  // Bus and map
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR        = 7'h6B;
  localparam logic [7:0] OFS_INPUT_SOURCE  = 8'h00;
  localparam logic [7:0] OFS_CHARGE_BOOST  = 8'h01;
  localparam logic [7:0] OFS_CHARGE_CURR   = 8'h02;
  localparam logic [7:0] OFS_LAST          = 8'h0B;
  localparam logic [7:0] READ_BEYOND_MAP   = 8'hFF;
  localparam logic [7:0] READ_UNBUILT      = 8'h00;
  // ---------------------------------------------------------------
  // Power-on values and watchdog masks
  // ---------------------------------------------------------------
  localparam logic [7:0] POR_INPUT_SOURCE  = 8'h17;
  localparam logic [7:0] POR_CHARGE_BOOST  = 8'h1A;
  localparam logic [7:0] POR_CHARGE_CURR   = 8'hA2;
  localparam logic [7:0] WD_INPUT_SOURCE   = 8'h80;
  localparam logic [7:0] WD_CHARGE_BOOST   = 8'h70;
  localparam logic [7:0] WD_CHARGE_CURR    = 8'hBF;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HIZ_BIT       = 7;
  localparam int STAT_MSB      = 6;
  localparam int STAT_LSB      = 5;
  localparam int ILIM_MSB      = 4;
  localparam int LIGHT_BIT     = 7;
  localparam int KICK_BIT      = 6;
  localparam int BOOST_BIT     = 5;
  localparam int CHG_BIT       = 4;
  localparam int SYSMIN_MSB    = 3;
  localparam int SYSMIN_LSB    = 1;
  localparam int BMIN_BIT      = 0;
  localparam int BLIM_BIT      = 7;
  localparam int FET_BIT       = 6;
  localparam int FAST_CHARGE_CURRENT_MSB      = 5;
  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] STAT_FLOAT        = 2'h3;
  localparam logic [4:0] ILIM_PSEL_HIGH    = 5'h04;
  localparam logic [4:0] ILIM_PSEL_LOW     = 5'h17;
  localparam logic [4:0] ILIM_FET_THRESH   = 5'h06;
  localparam logic [5:0] FAST_CHARGE_CURRENT_MAX          = 6'h32;
  localparam logic [5:0] FAST_CHARGE_CURRENT_OFF          = 6'h00;
endpackage
`default_nettype wire
